// *** design/rfc_frame_codec.sv ***
`default_nettype none
module rfc_frame_codec #(
    parameter int DEPTH = 64
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    output rfc_pkg::rfc_reg_req_t reg_req,
    input wire logic [15:0] reg_rdata,
    output logic done,
    output logic [7:0] done_status
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [31:0] MAX_BYTES = 32'(2 * DEPTH);
    localparam logic [AW:0] DEPTH_W = (AW + 1)'(DEPTH);

    typedef enum logic [3:0] {
        S_RX_HDR = 4'h0, S_CHECK = 4'h1, S_RX_DATA = 4'h2, S_VERIFY = 4'h3,
        S_COMMIT = 4'h4, S_FETCH = 4'h5, S_TX_HDR = 4'h6, S_TX_DATA = 4'h7,
        S_TX_END = 4'h8, S_DONE = 4'h9
    } rfc_state_t;

    rfc_state_t st_q;
    rfc_pkg::rfc_hdr_t hdr_q;
    rfc_pkg::rfc_reg_req_t reg_q;
    logic [5:0] pos_q, txpos_q;
    logic [15:0] pre_q, c16_q;
    logic [7:0] rev_q, hi_q, status_q, tx_data_q, hdr_byte;
    logic [31:0] c32_q, cnt_q, rlen, rcrc;
    logic [AW:0] idx_q, nwords;
    logic [1:0] ph_q;
    logic par_q, ok_q, txhdr_q, tx_valid_q, tx_last_q, rx_ready_q, done_q;
    logic rx_fire, can_load, len_ok, hdr_good, buf_we;
    logic [15:0] buf_wdata, buf_rdata;

    assign rx_ready = rx_ready_q;
    assign tx_valid = tx_valid_q;
    assign tx_data = tx_data_q;
    assign tx_last = tx_last_q;
    assign reg_req = reg_q;
    assign done = done_q;
    assign done_status = status_q;

    assign rx_fire = rx_valid && rx_ready_q;
    assign can_load = !tx_valid_q || tx_ready;
    assign nwords = hdr_q.len[AW+1:1];
    assign len_ok = !hdr_q.len[0] && (hdr_q.len != 32'h0) && (hdr_q.len <= MAX_BYTES);
    assign hdr_good = (pre_q == rfc_pkg::PREAMBLE) && (rev_q == rfc_pkg::FORMAT_REV)
        && (c16_q == hdr_q.hcrc);
    assign rlen = ok_q ? hdr_q.len : 32'h0;
    assign rcrc = ok_q ? c32_q : 32'h0;

    // ----------------------------------------------------------------
    // word buffer: write payload staged until its crc is known
    // ----------------------------------------------------------------
    // staging means a frame with a bad payload crc reaches a register only when its FLAG_SKIP_DCRC flag bit is set
    assign buf_we = (st_q == S_RX_DATA && rx_fire && par_q && idx_q < DEPTH_W)
        || (st_q == S_FETCH && ph_q == 2'h2);
    assign buf_wdata = (st_q == S_FETCH) ? reg_rdata : {hi_q, rx_data};

    rfc_word_buf #(.W(16), .DEPTH(DEPTH), .AW(AW)) u_buf (
        .clk(clk),
        .rst(rst),
        .we(buf_we),
        .waddr(idx_q[AW-1:0]),
        .wdata(buf_wdata),
        .raddr(idx_q[AW-1:0]),
        .rdata(buf_rdata)
    );

    // ----------------------------------------------------------------
    // response header byte by position
    // ----------------------------------------------------------------
    always_comb begin
        case (pos_q)
            rfc_pkg::OFS_PRE: hdr_byte = rfc_pkg::PREAMBLE[15:8];
            rfc_pkg::OFS_PRE + 6'h1: hdr_byte = rfc_pkg::PREAMBLE[7:0];
            rfc_pkg::OFS_REV: hdr_byte = rfc_pkg::FORMAT_REV;
            rfc_pkg::OFS_CMD: hdr_byte = rfc_pkg::CMD_READ;
            rfc_pkg::OFS_STATUS: hdr_byte = status_q;
            rfc_pkg::OFS_LEN: hdr_byte = rlen[31:24];
            rfc_pkg::OFS_LEN + 6'h1: hdr_byte = rlen[23:16];
            rfc_pkg::OFS_LEN + 6'h2: hdr_byte = rlen[15:8];
            rfc_pkg::OFS_LEN + 6'h3: hdr_byte = rlen[7:0];
            rfc_pkg::OFS_ADDR: hdr_byte = hdr_q.addr[15:8];
            rfc_pkg::OFS_ADDR + 6'h1: hdr_byte = hdr_q.addr[7:0];
            rfc_pkg::OFS_DCRC: hdr_byte = rcrc[31:24];
            rfc_pkg::OFS_DCRC + 6'h1: hdr_byte = rcrc[23:16];
            rfc_pkg::OFS_DCRC + 6'h2: hdr_byte = rcrc[15:8];
            rfc_pkg::OFS_DCRC + 6'h3: hdr_byte = rcrc[7:0];
            rfc_pkg::OFS_HCRC: hdr_byte = c16_q[15:8];
            rfc_pkg::OFS_HCRC + 6'h1: hdr_byte = c16_q[7:0];
            default: hdr_byte = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // received header capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hdr_q <= '0;
            pre_q <= 16'h0000;
            rev_q <= 8'h00;
        end else if (st_q == S_RX_HDR && rx_fire) begin
            case (pos_q)
                rfc_pkg::OFS_PRE, rfc_pkg::OFS_PRE + 6'h1: pre_q <= {pre_q[7:0], rx_data};
                rfc_pkg::OFS_REV: rev_q <= rx_data;
                rfc_pkg::OFS_CMD: hdr_q.cmd <= rx_data;
                rfc_pkg::OFS_FLAGS, rfc_pkg::OFS_FLAGS + 6'h1: begin
                    hdr_q.flags <= {hdr_q.flags[7:0], rx_data};
                end
                rfc_pkg::OFS_LEN, rfc_pkg::OFS_LEN + 6'h1,
                rfc_pkg::OFS_LEN + 6'h2, rfc_pkg::OFS_LEN + 6'h3: begin
                    hdr_q.len <= {hdr_q.len[23:0], rx_data};
                end
                rfc_pkg::OFS_ADDR, rfc_pkg::OFS_ADDR + 6'h1: begin
                    hdr_q.addr <= {hdr_q.addr[7:0], rx_data};
                end
                rfc_pkg::OFS_DCRC, rfc_pkg::OFS_DCRC + 6'h1,
                rfc_pkg::OFS_DCRC + 6'h2, rfc_pkg::OFS_DCRC + 6'h3: begin
                    hdr_q.dcrc <= {hdr_q.dcrc[23:0], rx_data};
                end
                rfc_pkg::OFS_HCRC, rfc_pkg::OFS_HCRC + 6'h1: begin
                    hdr_q.hcrc <= {hdr_q.hcrc[7:0], rx_data};
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // frame sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= S_RX_HDR;
            pos_q <= 6'h00;
            txpos_q <= 6'h00;
            c16_q <= rfc_pkg::CRC16_INIT;
            c32_q <= rfc_pkg::CRC32_INIT;
            cnt_q <= 32'h0;
            hi_q <= 8'h00;
            idx_q <= '0;
            ph_q <= 2'h0;
            par_q <= 1'b0;
            ok_q <= 1'b0;
            status_q <= rfc_pkg::RES_OK;
            txhdr_q <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_data_q <= 8'h00;
            tx_last_q <= 1'b0;
            rx_ready_q <= 1'b0;
            reg_q <= '0;
            done_q <= 1'b0;
        end else begin
            reg_q.wr <= 1'b0;
            reg_q.rd <= 1'b0;
            done_q <= 1'b0;
            if (tx_valid_q && tx_ready) begin
                tx_valid_q <= 1'b0;
                tx_last_q <= 1'b0;
            end
            case (st_q)
                S_RX_HDR: begin
                    rx_ready_q <= 1'b1;
                    if (rx_fire) begin
                        pos_q <= pos_q + 6'h1;
                        if (pos_q == rfc_pkg::OFS_PRE) begin
                            c16_q <= rfc_pkg::CRC16_INIT;
                            c32_q <= rfc_pkg::CRC32_INIT;
                        end
                        if (pos_q >= rfc_pkg::HCRC_FIRST && pos_q <= rfc_pkg::HCRC_LAST) begin
                            c16_q <= rfc_pkg::crc16_byte(c16_q, rx_data);
                        end
                        if (pos_q == rfc_pkg::HDR_LAST) begin
                            rx_ready_q <= 1'b0;
                            st_q <= S_CHECK;
                        end
                    end
                end
                S_CHECK: begin
                    pos_q <= 6'h00;
                    idx_q <= '0;
                    ph_q <= 2'h0;
                    par_q <= 1'b0;
                    ok_q <= 1'b0;
                    cnt_q <= hdr_q.len;
                    c16_q <= rfc_pkg::CRC16_INIT;
                    status_q <= rfc_pkg::RES_FAIL;
                    if (!hdr_good) begin
                        // a read still gets an answer; anything else only flags done
                        st_q <= (hdr_q.cmd == rfc_pkg::CMD_READ) ? S_TX_HDR : S_DONE;
                    end else if (hdr_q.cmd == rfc_pkg::CMD_WRITE) begin
                        st_q <= (hdr_q.len == 32'h0) ? S_VERIFY : S_RX_DATA;
                        rx_ready_q <= (hdr_q.len != 32'h0);
                    end else if (hdr_q.cmd == rfc_pkg::CMD_READ) begin
                        st_q <= len_ok ? S_FETCH : S_TX_HDR;
                    end else begin
                        st_q <= S_DONE;
                    end
                end
                S_RX_DATA: begin
                    // the whole declared payload is drained even when too long to keep
                    if (rx_fire) begin
                        c32_q <= rfc_pkg::crc32_byte(c32_q, rx_data);
                        par_q <= ~par_q;
                        if (!par_q) begin
                            hi_q <= rx_data;
                        end else if (idx_q < DEPTH_W) begin
                            idx_q <= idx_q + 1'b1;
                        end
                        cnt_q <= cnt_q - 32'h1;
                        if (cnt_q == 32'h1) begin
                            rx_ready_q <= 1'b0;
                            st_q <= S_VERIFY;
                        end
                    end
                end
                S_VERIFY: begin
                    idx_q <= '0;
                    ph_q <= 2'h0;
                    if (len_ok && (hdr_q.flags[rfc_pkg::FLAG_SKIP_DCRC]
                        || c32_q == hdr_q.dcrc)) begin
                        st_q <= S_COMMIT;
                    end else begin
                        st_q <= S_DONE;
                    end
                end
                S_COMMIT: begin
                    if (ph_q == 2'h0) begin
                        ph_q <= 2'h1;
                    end else begin
                        reg_q.wr <= 1'b1;
                        reg_q.addr <= hdr_q.addr + 16'(idx_q);
                        reg_q.wdata <= buf_rdata;
                        idx_q <= idx_q + 1'b1;
                        ph_q <= 2'h0;
                        if (idx_q + 1'b1 == nwords) begin
                            status_q <= rfc_pkg::RES_OK;
                            st_q <= S_DONE;
                        end
                    end
                end
                S_FETCH: begin
                    if (ph_q == 2'h0) begin
                        reg_q.rd <= 1'b1;
                        reg_q.addr <= hdr_q.addr + 16'(idx_q);
                        ph_q <= 2'h1;
                    end else if (ph_q == 2'h1) begin
                        ph_q <= 2'h2;
                    end else begin
                        c32_q <= rfc_pkg::crc32_byte(rfc_pkg::crc32_byte(c32_q,
                            reg_rdata[15:8]), reg_rdata[7:0]);
                        ph_q <= 2'h0;
                        if (idx_q + 1'b1 == nwords) begin
                            idx_q <= '0;
                            ok_q <= 1'b1;
                            status_q <= rfc_pkg::RES_OK;
                            st_q <= S_TX_HDR;
                        end else begin
                            idx_q <= idx_q + 1'b1;
                        end
                    end
                end
                S_TX_HDR: begin
                    if (can_load) begin
                        tx_data_q <= hdr_byte;
                        tx_valid_q <= 1'b1;
                        txpos_q <= pos_q;
                        txhdr_q <= 1'b1;
                        pos_q <= pos_q + 6'h1;
                        if (pos_q >= rfc_pkg::HCRC_FIRST && pos_q <= rfc_pkg::HCRC_LAST) begin
                            c16_q <= rfc_pkg::crc16_byte(c16_q, hdr_byte);
                        end
                        if (pos_q == rfc_pkg::HDR_LAST) begin
                            ph_q <= 2'h0;
                            tx_last_q <= !ok_q;
                            st_q <= ok_q ? S_TX_DATA : S_TX_END;
                        end
                    end
                end
                S_TX_DATA: begin
                    // one idle phase per word lets the buffer read settle
                    if (ph_q == 2'h0) begin
                        ph_q <= 2'h1;
                    end else if (can_load) begin
                        tx_valid_q <= 1'b1;
                        txhdr_q <= 1'b0;
                        if (ph_q == 2'h1) begin
                            tx_data_q <= buf_rdata[15:8];
                            ph_q <= 2'h2;
                        end else begin
                            tx_data_q <= buf_rdata[7:0];
                            ph_q <= 2'h0;
                            idx_q <= idx_q + 1'b1;
                            if (idx_q + 1'b1 == nwords) begin
                                tx_last_q <= 1'b1;
                                st_q <= S_TX_END;
                            end
                        end
                    end
                end
                S_TX_END: begin
                    if (can_load) begin
                        st_q <= S_DONE;
                    end
                end
                S_DONE: begin
                    done_q <= 1'b1;
                    pos_q <= 6'h00;
                    st_q <= S_RX_HDR;
                end
                default: st_q <= S_RX_HDR;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_hdr_at(logic [5:0] p);
        tx_valid_q && txhdr_q && txpos_q == p;
    endsequence
    property p_preamble;
        @(posedge clk) disable iff (rst)
        s_hdr_at(6'h00) |-> tx_data_q == 8'ha1;
    endproperty
    a_preamble: assert property (p_preamble) else $error("bad marker byte");
    property p_rev;
        @(posedge clk) disable iff (rst) s_hdr_at(6'h02) |-> tx_data_q == 8'h03;
    endproperty
    a_rev: assert property (p_rev) else $error("bad revision byte");
    property p_cmd;
        @(posedge clk) disable iff (rst) s_hdr_at(6'h03) |-> tx_data_q == 8'h03;
    endproperty
    a_cmd: assert property (p_cmd) else $error("bad command byte");
    property p_addr;
        @(posedge clk) disable iff (rst) s_hdr_at(6'h0c) |-> tx_data_q == hdr_q.addr[15:8];
    endproperty
    a_addr: assert property (p_addr) else $error("bad address byte");
    property p_len;
        @(posedge clk) disable iff (rst)
        s_hdr_at(6'h0b) |-> tx_data_q == (ok_q ? hdr_q.len[7:0] : 8'h00);
    endproperty
    a_len: assert property (p_len) else $error("bad length byte");
    property p_no_write_bad_hdr;
        @(posedge clk) disable iff (rst)
        (st_q == S_CHECK && !hdr_good) |=> !reg_q.wr [*8];
    endproperty
    a_no_write_bad_hdr: assert property (p_no_write_bad_hdr) else $error("write after bad header");
    property p_consecutive;
        @(posedge clk) disable iff (rst)
        reg_q.wr ##2 reg_q.wr |-> reg_q.addr == $past(reg_q.addr, 2) + 16'h1;
    endproperty
    a_consecutive: assert property (p_consecutive) else $error("write address skipped");
    property p_skip_crc;
        @(posedge clk) disable iff (rst)
        (st_q == S_VERIFY && len_ok && hdr_q.flags[0]) |=> ##2 reg_q.wr;
    endproperty
    a_skip_crc: assert property (p_skip_crc) else $error("flagged write not committed");
endmodule
`default_nettype wire

// *** design/rfc_pkg.sv ***
`default_nettype none
package rfc_pkg;
    // ----------------------------------------------------------------
    // frame constants
    // ----------------------------------------------------------------
    localparam logic [15:0] PREAMBLE = 16'ha1ec;
    localparam logic [7:0] FORMAT_REV = 8'h03;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_WRITE = 8'h04;
    localparam logic [5:0] OFS_PRE = 6'h00;
    localparam logic [5:0] OFS_REV = 6'h02;
    localparam logic [5:0] OFS_CMD = 6'h03;
    localparam logic [5:0] OFS_STATUS = 6'h05;
    localparam logic [5:0] OFS_FLAGS = 6'h06;
    localparam logic [5:0] OFS_LEN = 6'h08;
    localparam logic [5:0] OFS_ADDR = 6'h0c;
    localparam logic [5:0] OFS_DCRC = 6'h3a;
    localparam logic [5:0] OFS_HCRC = 6'h3e;
    localparam logic [5:0] HCRC_FIRST = 6'h02;
    localparam logic [5:0] HCRC_LAST = 6'h3d;
    localparam logic [5:0] HDR_LAST = 6'h3f;
    localparam int FLAG_SKIP_DCRC = 0;
    localparam logic [15:0] CRC16_POLY = 16'h1021;
    localparam logic [15:0] CRC16_INIT = 16'h0000;
    localparam logic [31:0] CRC32_POLY = 32'h04c11db7;
    // start value kept exactly as specified: seven f digits
    localparam logic [31:0] CRC32_INIT = 32'h0fffffff;
    localparam logic [7:0] RES_OK = 8'h00;
    localparam logic [7:0] RES_FAIL = 8'h01;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cmd;
        logic [15:0] flags;
        logic [31:0] len;
        logic [15:0] addr;
        logic [31:0] dcrc;
        logic [15:0] hcrc;
    } rfc_hdr_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } rfc_reg_req_t;

    // ----------------------------------------------------------------
    // bytewise crc, msb first, no reflection, no final xor
    // ----------------------------------------------------------------
    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ CRC16_POLY) : (r << 1);
        end
        return r;
    endfunction

    function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {b, 24'h000000};
        for (int i = 0; i < 8; i++) begin
            r = r[31] ? ((r << 1) ^ CRC32_POLY) : (r << 1);
        end
        return r;
    endfunction
endpackage
`default_nettype wire

// *** design/rfc_word_buf.sv ***
`default_nettype none
module rfc_word_buf #(
    parameter int W = 16,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// *** verification/rfc_frame_codec_tb.sv ***
`default_nettype none
module rfc_frame_codec_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_ready;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic tx_ready;
    rfc_pkg::rfc_reg_req_t reg_req;
    logic [15:0] reg_rdata = 16'h0000;
    logic done;
    logic [7:0] done_status;
    logic [15:0] regs [0:255];
    int nwr = 0;
    int miscompares = 0;
    int total_checks = 0;

    always #5 clk = ~clk;

    rfc_frame_codec #(.DEPTH(64)) dut (.clk(clk), .rst(rst), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .done(done), .done_status(done_status));
    rfc_host_model host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready));

    // ----------------------------------------------------------------
    // register file, one cycle read latency
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < 256; i++) regs[i] = 16'(i * 16'h0107);
    end
    always @(posedge clk) begin
        if (reg_req.wr === 1'b1) begin
            regs[reg_req.addr[7:0]] = reg_req.wdata;
            nwr++;
        end
        if (reg_req.rd === 1'b1) reg_rdata <= #1 regs[reg_req.addr[7:0]];
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic limit_hit();
        miscompares++;
        $display("Error wait limit expected 1 seen 0");
        stop_test();
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic wr_case(input logic [15:0] fl, input logic [31:0] dx, input logic [7:0] st,
                           input int n);
        int t;
        int w0;
        t = 0;
        w0 = nwr;
        host.wq = {16'h1234 ^ fl, 16'hbeef, 16'h00a5 ^ fl};
        host.build(8'h04, 8'h5a, fl, 32'd6, 16'h0010, 8'h5a, dx);
        host.send();
        while (done !== 1'b1 && t < 3000) begin
            @(posedge clk);
            t++;
        end
        if (t >= 3000) limit_hit();
        check("done_status", st, done_status);
        check("write count", n, nwr - w0);
        for (int i = 0; i < n; i++) check("register", host.wq[i], regs[16 + i]);
        #1;
    endtask

    // response compared byte for byte, the sink stalling on good reads
    task automatic rd_case(input logic [7:0] p0, input logic [31:0] len, input logic [7:0] st);
        int t;
        t = 0;
        host.wq = {};
        host.build(8'h03, 8'h5a, 16'h0000, len, 16'h0020, 8'h5a, 32'h0);
        host.f[0] = p0;
        host.rsp = {};
        host.last_at = 0;
        host.slow = (st == 8'h00);
        host.send();
        while (host.last_at == 0 && t < 3000) begin
            @(posedge clk);
            t++;
        end
        if (t >= 3000) limit_hit();
        for (int i = 0; i < len / 2 && st == 8'h00; i++) host.wq.push_back(regs[32 + i]);
        host.build(8'h03, st, 16'h0000, (st == 8'h00) ? len : 32'h0, 16'h0020, 8'h00, 32'h0);
        check("response size", host.f.size(), host.rsp.size());
        check("last byte position", host.f.size(), host.last_at);
        for (int i = 0; i < host.f.size(); i++) check("response byte", host.f[i], host.rsp[i]);
        host.slow = 0;
        #1;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        @(posedge clk);
        #1;
        wr_case(16'h0000, 32'h0, 8'h00, 3);
        wr_case(16'h0000, 32'h1, 8'h01, 0);
        wr_case(16'h0001, 32'h1, 8'h00, 3);
        rd_case(8'ha1, 32'd6, 8'h00);
        rd_case(8'h00, 32'd6, 8'h01);
        rd_case(8'ha1, 32'd5, 8'h01);
        stop_test();
    end
endmodule
`default_nettype wire

// *** verification/rfc_host_model.sv ***
`default_nettype none
module rfc_host_model (
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] f[$];
    logic [15:0] wq[$];
    logic [7:0] rsp[$];
    int last_at = 0;
    bit slow = 0;

    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
    end

    // ----------------------------------------------------------------
    // msb-first crc over f[a +: n], w is 16 or 32
    // ----------------------------------------------------------------
    function automatic logic [31:0] crc(input int w, input logic [31:0] p, input logic [31:0] c,
                                        input int a, input int n);
        logic [31:0] r;
        r = c;
        for (int i = a; i < a + n; i++) begin
            r = r ^ (32'(f[i]) << (w - 8));
            for (int k = 0; k < 8; k++) begin
                r = r[w-1] ? ((r << 1) ^ p) : (r << 1);
            end
        end
        return (w == 16) ? {16'h0000, r[15:0]} : r;
    endfunction

    // ----------------------------------------------------------------
    // frame image; fill lands in every ignored byte
    // ----------------------------------------------------------------
    task automatic build(input logic [7:0] cmd, input logic [7:0] st, input logic [15:0] fl,
                         input logic [31:0] len, input logic [15:0] ad, input logic [7:0] fill,
                         input logic [31:0] dx);
        logic [31:0] dc;
        logic [15:0] hc;
        f = {8'ha1, 8'hec, 8'h03, cmd, fill, st, fl[15:8], fl[7:0], len[31:24], len[23:16],
             len[15:8], len[7:0], ad[15:8], ad[7:0]};
        repeat (50) f.push_back(fill);
        foreach (wq[i]) begin
            f.push_back(wq[i][15:8]);
            f.push_back(wq[i][7:0]);
        end
        dc = (wq.size() > 0) ? crc(32, 32'h04c11db7, 32'h0fffffff, 64, f.size() - 64) : 32'h0;
        dc = dc ^ dx;
        for (int i = 0; i < 4; i++) f[58 + i] = dc[31 - 8 * i -: 8];
        hc = 16'(crc(16, 32'h1021, 32'h0, 2, 60));
        f[62] = hc[15:8];
        f[63] = hc[7:0];
    endtask

    // each byte held until taken; data scrambled once released
    // frames follow back to back, far inside the idle limit
    task automatic send();
        int t;
        foreach (f[i]) begin
            rx_valid <= 1'b1;
            rx_data <= f[i];
            t = 0;
            do begin
                @(posedge clk);
                t++;
            end while (rx_ready !== 1'b1 && t < 500);
            if (t >= 500) rfc_frame_codec_tb.limit_hit();
            #1;
        end
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
    endtask

    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            rsp.push_back(tx_data);
            if (tx_last === 1'b1) last_at = rsp.size();
        end
        #1;
        tx_ready <= slow ? !tx_ready : 1'b1;
    end
endmodule
`default_nettype wire
